// ---- design/tms_mode_reg.sv ----
// Storage of the timer mode register fields
`timescale 1ns/1ps
`include "tms_regs.svh"

module tms_mode_reg
    import tms_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   wr_en_i,
    input  wire logic [`TMS_MODE_W-1:0] wdata_i,
    output tms_mode_t                   mode_o
);

    tms_mode_t mode_q;
    tms_mode_t mode_d;

    always_comb
    begin
        mode_d = mode_q;
        if (wr_en_i)
        begin
            mode_d = tms_byte_to_mode(wdata_i);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_q <= TMS_MODE_RST;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    assign mode_o = mode_q;

endmodule // tms_mode_reg

// ---- design/tms_pkg.sv ----
// Types and field conversions shared by the timer mode slice
package tms_pkg;

`include "tms_regs.svh"

    typedef enum logic {TMS_FN_CAPCMP, TMS_FN_BUFFER} tms_fn_t;
    typedef enum logic {TMS_PIN_OC, TMS_PIN_PWM} tms_pin_mode_t;

    typedef struct packed {
        logic          count_run;
        tms_fn_t       buf_b_sel;
        tms_fn_t       buf_a_sel;
        tms_pin_mode_t pin_d_pwm;
        tms_pin_mode_t pin_c_pwm;
        tms_pin_mode_t pin_b_pwm;
    } tms_mode_t;

    typedef struct packed {
        logic [`TMS_DATA_W-1:0] rdata;
        logic [`TMS_DATA_W-1:0] count;
        logic                   mode_seen;
    } tms_top_state_t;

    localparam tms_mode_t TMS_MODE_RST = '{
        count_run: 1'b0,
        buf_b_sel: TMS_FN_CAPCMP,
        buf_a_sel: TMS_FN_CAPCMP,
        pin_d_pwm: TMS_PIN_OC,
        pin_c_pwm: TMS_PIN_OC,
        pin_b_pwm: TMS_PIN_OC
    };

    function automatic logic [`TMS_MODE_W-1:0] tms_mode_to_byte(
        input tms_mode_t m
    );
        logic [`TMS_MODE_W-1:0] b;
        b = `TMS_MODE_RSVD;
        b[`TMS_BIT_RUN]   = m.count_run;
        b[`TMS_BIT_BUF_B] = m.buf_b_sel;
        b[`TMS_BIT_BUF_A] = m.buf_a_sel;
        b[`TMS_BIT_PWM_D] = m.pin_d_pwm;
        b[`TMS_BIT_PWM_C] = m.pin_c_pwm;
        b[`TMS_BIT_PWM_B] = m.pin_b_pwm;
        return b;
    endfunction

    // Reserved bits are simply not picked up, so writes to them vanish
    function automatic tms_mode_t tms_byte_to_mode(
        input logic [`TMS_MODE_W-1:0] b
    );
        tms_mode_t m;
        m.count_run = b[`TMS_BIT_RUN];
        m.buf_b_sel = tms_fn_t'(b[`TMS_BIT_BUF_B]);
        m.buf_a_sel = tms_fn_t'(b[`TMS_BIT_BUF_A]);
        m.pin_d_pwm = tms_pin_mode_t'(b[`TMS_BIT_PWM_D]);
        m.pin_c_pwm = tms_pin_mode_t'(b[`TMS_BIT_PWM_C]);
        m.pin_b_pwm = tms_pin_mode_t'(b[`TMS_BIT_PWM_B]);
        return m;
    endfunction

endpackage

// ---- design/tms_regs.svh ----
// Register offsets, bit positions and reset values of the timer mode slice
`ifndef TMS_REGS_SVH
`define TMS_REGS_SVH

`define TMS_ADDR_W        4
`define TMS_DATA_W        16
`define TMS_MODE_W        8

`define TMS_MODE_OFS      4'h0
`define TMS_CNT_OFS       4'h1

`define TMS_BIT_RUN       7
`define TMS_BIT_RSVD_HI   6
`define TMS_BIT_BUF_B     5
`define TMS_BIT_BUF_A     4
`define TMS_BIT_RSVD_LO   3
`define TMS_BIT_PWM_D     2
`define TMS_BIT_PWM_C     1
`define TMS_BIT_PWM_B     0

`define TMS_MODE_RSVD     8'h48
`define TMS_MODE_RST_RD   8'h48
`define TMS_CNT_RST       16'h0000
`define TMS_CNT_STEP      16'h0001
`define TMS_RDATA_IDLE    16'h0000
`define TMS_PAD_ZERO      8'h00

`endif

// ---- design/tms_top.sv ----
// Timer mode select slice: mode register, channel routing, counter gate
//
// Notes on behaviour
// - Buffer-A clear: register C captures/compares alone
// - Buffer-A set: register C buffers register A
// - Buffer-B set: register D buffers register B
// - Bit 3 reserved, ignores writes, reads 1
// - Bit 2 picks pin D compare or PWM
// - Bit 1 picks pin C compare or PWM
// - Bit 0 picks pin B compare or PWM
// - Buffer-A bit read/write, reset to 0
// - Buffer-B clear: register D captures/compares alone
// - Bit 7 halts or runs the counter
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "tms_regs.svh"

module tms_top
    import tms_pkg::*;
(
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RST_N_I,
    input  wire logic [`TMS_ADDR_W-1:0] ADDR_I,
    input  wire logic [`TMS_DATA_W-1:0] WDATA_I,
    input  wire logic                   WR_I,
    input  wire logic                   RD_I,
    output logic      [`TMS_DATA_W-1:0] RDATA_O,
    output tms_fn_t                     REG_C_FUNC_O,
    output tms_fn_t                     REG_D_FUNC_O,
    output tms_pin_mode_t               PIN_B_MODE_O,
    output tms_pin_mode_t               PIN_C_MODE_O,
    output tms_pin_mode_t               PIN_D_MODE_O,
    output logic                        COUNT_RUN_O,
    output logic      [`TMS_DATA_W-1:0] COUNT_O
);

    tms_top_state_t st_q;
    tms_top_state_t st_d;
    tms_mode_t      mode;
    logic           mode_wr;
    logic           cnt_wr;
    logic           mode_rd;
    logic           cnt_rd;

    // One address compare shared by every strobe decode
    function automatic logic addr_hit(
        input logic [`TMS_ADDR_W-1:0] addr,
        input logic [`TMS_ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    assign mode_wr = WR_I && addr_hit(ADDR_I, `TMS_MODE_OFS);
    assign cnt_wr  = WR_I && addr_hit(ADDR_I, `TMS_CNT_OFS);
    assign mode_rd = RD_I && addr_hit(ADDR_I, `TMS_MODE_OFS);
    assign cnt_rd  = RD_I && addr_hit(ADDR_I, `TMS_CNT_OFS);

    // Upper byte of a mode write is dropped; the register is eight bits
    tms_mode_reg u_mode_reg (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RST_N_I),
        .wr_en_i (mode_wr),
        .wdata_i (WDATA_I[`TMS_MODE_W-1:0]),
        .mode_o  (mode)
    );

    always_comb
    begin
        st_d = st_q;
        // Read data stand for the one cycle after the strobe only
        st_d.rdata = `TMS_RDATA_IDLE;
        if (RD_I)
        begin
            unique case (ADDR_I)
                `TMS_MODE_OFS:
                begin
                    st_d.rdata = {`TMS_PAD_ZERO,
                                  tms_mode_to_byte(mode)};
                end
                `TMS_CNT_OFS:
                begin
                    st_d.rdata = st_q.count;
                end
                default:
                begin
                    st_d.rdata = `TMS_RDATA_IDLE;
                end
            endcase
        end
        // A software load wins over the count step of the same cycle
        if (cnt_wr)
        begin
            st_d.count = WDATA_I;
        end
        else if (mode.count_run)
        begin
            st_d.count = st_q.count + `TMS_CNT_STEP;
        end
        // Only the checks read this; synthesis trims it away
        if (mode_wr)
        begin
            st_d.mode_seen = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            st_q.rdata <= `TMS_RDATA_IDLE;
            st_q.count <= `TMS_CNT_RST;
            st_q.mode_seen <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign RDATA_O      = st_q.rdata;
    assign COUNT_O      = st_q.count;
    assign REG_C_FUNC_O = mode.buf_a_sel;
    assign REG_D_FUNC_O = mode.buf_b_sel;
    assign PIN_D_MODE_O = mode.pin_d_pwm;
    assign PIN_C_MODE_O = mode.pin_c_pwm;
    assign PIN_B_MODE_O = mode.pin_b_pwm;
    assign COUNT_RUN_O  = mode.count_run;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking

    default disable iff (!RST_N_I);

    AST_REG_C_CAPCMP: assert property (
        mode_wr && !WDATA_I[`TMS_BIT_BUF_A]
        |=> REG_C_FUNC_O == TMS_FN_CAPCMP
    ) else $error("Register C not independent after clear");

    AST_REG_C_BUFFER: assert property (
        mode_wr && WDATA_I[`TMS_BIT_BUF_A]
        |=> REG_C_FUNC_O == TMS_FN_BUFFER
            ##1 ($past(mode_wr) || REG_C_FUNC_O == TMS_FN_BUFFER)
    ) else $error("Register C not acting as buffer after set");

    AST_REG_D_BUFFER: assert property (
        mode_wr && WDATA_I[`TMS_BIT_BUF_B]
        |=> REG_D_FUNC_O == TMS_FN_BUFFER
    ) else $error("Register D not acting as buffer after set");

    AST_REG_D_CAPCMP: assert property (
        mode_wr && !WDATA_I[`TMS_BIT_BUF_B]
        |=> REG_D_FUNC_O == TMS_FN_CAPCMP
    ) else $error("Register D not independent after clear");

    AST_RSVD_READS_ONE: assert property (
        RD_I && ADDR_I == `TMS_MODE_OFS
        |=> RDATA_O[`TMS_BIT_RSVD_LO] && RDATA_O[`TMS_BIT_RSVD_HI]
    ) else $error("Reserved mode bits did not read as one");

    AST_PIN_D_MODE: assert property (
        mode_wr
        |=> PIN_D_MODE_O == tms_pin_mode_t'($past(WDATA_I[`TMS_BIT_PWM_D]))
    ) else $error("Pin D mode does not follow written bit");

    AST_PIN_C_MODE: assert property (
        mode_wr
        |=> PIN_C_MODE_O == tms_pin_mode_t'($past(WDATA_I[`TMS_BIT_PWM_C]))
    ) else $error("Pin C mode does not follow written bit");

    AST_PIN_B_MODE: assert property (
        mode_wr
        |=> PIN_B_MODE_O == tms_pin_mode_t'($past(WDATA_I[`TMS_BIT_PWM_B]))
    ) else $error("Pin B mode does not follow written bit");

    AST_BUF_A_READBACK: assert property (
        mode_wr ##1 (RD_I && ADDR_I == `TMS_MODE_OFS)
        |=> RDATA_O[`TMS_BIT_BUF_A] == $past(WDATA_I[`TMS_BIT_BUF_A], 2)
    ) else $error("Buffer-A bit did not read back as written");

    AST_BUF_A_RESET: assert property (
        !st_q.mode_seen |-> REG_C_FUNC_O == TMS_FN_CAPCMP
    ) else $error("Buffer-A bit not clear before first write");

    AST_PIN_B_RESET: assert property (
        !st_q.mode_seen |-> PIN_B_MODE_O == TMS_PIN_OC && !COUNT_RUN_O
    ) else $error("Pin B mode or run bit not clear after reset");

    AST_COUNT_RUNS: assert property (
        COUNT_RUN_O && !cnt_wr
        |=> COUNT_O == $past(COUNT_O) + `TMS_CNT_STEP
    ) else $error("Counter did not step while running");

    AST_COUNT_HALTS: assert property (
        !COUNT_RUN_O && !cnt_wr [*2] |=> $stable(COUNT_O)
    ) else $error("Counter moved while halted");

    AST_RDATA_ONE_CYCLE: assert property (
        !RD_I |=> RDATA_O == `TMS_RDATA_IDLE
    ) else $error("Read data present without a read strobe");

    AST_BUF_B_RESET: assert property (
        !st_q.mode_seen
        |-> REG_D_FUNC_O == TMS_FN_CAPCMP
    ) else $error("Buffer-B bit not clear before first write");

    AST_PIN_C_RESET: assert property (
        !st_q.mode_seen
        |-> PIN_C_MODE_O == TMS_PIN_OC
    ) else $error("Pin C mode not clear before first write");

    AST_PIN_D_RESET: assert property (
        !st_q.mode_seen
        |-> PIN_D_MODE_O == TMS_PIN_OC
    ) else $error("Pin D mode not clear before first write");

    AST_REG_C_HOLDS: assert property (
        !mode_wr
        |=> $stable(REG_C_FUNC_O)
    ) else $error("Register C function changed without a write");

    AST_REG_D_HOLDS: assert property (
        !mode_wr
        |=> $stable(REG_D_FUNC_O)
    ) else $error("Register D function changed without a write");

    AST_PINS_HOLD: assert property (
        !mode_wr
        |=> $stable(PIN_B_MODE_O) && $stable(PIN_C_MODE_O)
            && $stable(PIN_D_MODE_O)
    ) else $error("Pin mode changed without a write");

    AST_RUN_FOLLOWS: assert property (
        mode_wr
        |=> COUNT_RUN_O == $past(WDATA_I[`TMS_BIT_RUN])
    ) else $error("Run gate does not follow written bit");

    AST_RUN_HOLDS: assert property (
        !mode_wr
        |=> $stable(COUNT_RUN_O)
    ) else $error("Run gate changed without a write");

    AST_REG_C_FOLLOWS: assert property (
        mode_wr
        |=> REG_C_FUNC_O == tms_fn_t'($past(WDATA_I[`TMS_BIT_BUF_A]))
    ) else $error("Register C function does not follow written bit");

    AST_REG_D_FOLLOWS: assert property (
        mode_wr
        |=> REG_D_FUNC_O == tms_fn_t'($past(WDATA_I[`TMS_BIT_BUF_B]))
    ) else $error("Register D function does not follow written bit");

    AST_RSVD_WRITE_IGNORED: assert property (
        mode_wr && !WDATA_I[`TMS_BIT_RSVD_LO] ##1 mode_rd
        |=> RDATA_O[`TMS_BIT_RSVD_LO]
    ) else $error("Reserved bit took a written zero");

    AST_BUF_B_READBACK: assert property (
        mode_wr ##1 mode_rd
        |=> RDATA_O[`TMS_BIT_BUF_B] == $past(WDATA_I[`TMS_BIT_BUF_B], 2)
    ) else $error("Buffer-B bit did not read back as written");

    AST_PWM_READBACK: assert property (
        mode_wr ##1 mode_rd
        |=> RDATA_O[`TMS_BIT_PWM_D:`TMS_BIT_PWM_B]
            == $past(WDATA_I[`TMS_BIT_PWM_D:`TMS_BIT_PWM_B], 2)
    ) else $error("Pin mode bits did not read back as written");

    AST_RUN_READBACK: assert property (
        mode_wr ##1 mode_rd
        |=> RDATA_O[`TMS_BIT_RUN] == $past(WDATA_I[`TMS_BIT_RUN], 2)
    ) else $error("Run bit did not read back as written");

    AST_MODE_UPPER_ZERO: assert property (
        mode_rd
        |=> RDATA_O[`TMS_DATA_W-1:`TMS_MODE_W] == `TMS_PAD_ZERO
    ) else $error("Mode read shows data above the mode byte");

    AST_CNT_READ: assert property (
        cnt_rd
        |=> RDATA_O == $past(COUNT_O)
    ) else $error("Counter read does not return the count");

    AST_UNMAPPED_READ_ZERO: assert property (
        RD_I && !mode_rd && !cnt_rd
        |=> RDATA_O == `TMS_RDATA_IDLE
    ) else $error("Unmapped read returned data");

    AST_COUNT_LOAD: assert property (
        cnt_wr
        |=> COUNT_O == $past(WDATA_I)
    ) else $error("Counter did not load the written value");

    COV_BUF_A_ON: cover property (
        mode_wr && WDATA_I[`TMS_BIT_BUF_A] ##1
        REG_C_FUNC_O == TMS_FN_BUFFER
    );

    COV_ALL_PWM: cover property (
        PIN_B_MODE_O == TMS_PIN_PWM && PIN_C_MODE_O == TMS_PIN_PWM &&
        PIN_D_MODE_O == TMS_PIN_PWM
    );

    COV_COUNT_RUN: cover property (
        COUNT_RUN_O [*3] ##1 !COUNT_RUN_O
    );

    COV_COUNT_WRAP: cover property (
        COUNT_RUN_O && COUNT_O == '1 ##1 COUNT_O == `TMS_CNT_RST
    );

    COV_WRITE_READ: cover property (
        mode_wr ##1 (RD_I && ADDR_I == `TMS_MODE_OFS)
    );

endmodule // tms_top

// ---- test/tms_tb.sv ----
// Self-checking bench for the timer mode select slice
`timescale 1ns/1ps
`include "tms_regs.svh"

module testbench;
    logic        clk;
    logic        rst_n;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        c_fn, d_fn, b_pm, c_pm, d_pm, run;
    logic [15:0] count;
    logic        rd_taken;
    logic [7:0]  mode_m;
    logic [31:0] seed;
    logic [15:0] exp_q[$];
    logic [15:0] v;
    logic [3:0]  a;
    int          fail_count;
    int          comparisons;

    tms_top i_dut (
        .SYS_CLK_I    (clk),
        .RST_N_I      (rst_n),
        .ADDR_I       (addr),
        .WDATA_I      (wdata),
        .WR_I         (wr),
        .RD_I         (rd),
        .RDATA_O      (rdata),
        .REG_C_FUNC_O (c_fn),
        .REG_D_FUNC_O (d_fn),
        .PIN_B_MODE_O (b_pm),
        .PIN_C_MODE_O (c_pm),
        .PIN_D_MODE_O (d_pm),
        .COUNT_RUN_O  (run),
        .COUNT_O      (count)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reserved bits 6 and 3 read as one whatever was written
    function automatic logic [15:0] exp_rd(input logic [3:0] ra);
        if (ra == `TMS_MODE_OFS)
            return {8'h00, mode_m[7], 1'b1, mode_m[5:4], 1'b1, mode_m[2:0]};
        return 16'h0000;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, msg, got, exp);
        end
    endtask

    // One bus cycle; an idle cycle is acc(0, 0, ...)
    task automatic acc(input logic w, input logic r, input logic [3:0] ba,
                       input logic [15:0] bd);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= ba;
        wdata <= bd;
        if (w && ba == `TMS_MODE_OFS)
            mode_m = bd[7:0];
        if (r)
            exp_q.push_back(exp_rd(ba));
    endtask

    task automatic chk_mode();
        @(negedge clk);
        chk({10'h000, run, d_fn, c_fn, d_pm, c_pm, b_pm},
            {10'h000, mode_m[7], mode_m[5], mode_m[4], mode_m[2:0]},
            "mode outputs");
    endtask

    // Read data stand only in the cycle after the strobe, else zero
    always @(posedge clk) rd_taken <= rd;
    always @(negedge clk)
    begin
        if (rst_n && rd_taken)
            chk(rdata, exp_q.pop_front(), "read data");
        else if (rst_n)
            chk(rdata, 16'h0000, "idle read data");
    end

    task automatic close_out();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #(3000 * 20);
        fail_count++;
        close_out();
    end

    initial
    begin
        seed = 32'h5;
        fail_count = 0;
        comparisons = 0;
        mode_m = 8'h00;
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk_mode();
        chk(count, 16'h0000, "count after reset");
        acc(1'b0, 1'b1, `TMS_MODE_OFS, 16'h0000);
        acc(1'b1, 1'b0, `TMS_MODE_OFS, 16'h00FF);
        acc(1'b0, 1'b1, `TMS_MODE_OFS, 16'h0000);
        chk_mode();
        // Random writes, unmapped ones among them, each read straight back
        repeat (40)
        begin
            a = xs() & 16'hF;
            if (a == `TMS_CNT_OFS)
                a = `TMS_MODE_OFS;
            acc(1'b1, 1'b0, a, xs() & 16'hFFFF);
            acc(1'b0, 1'b1, `TMS_MODE_OFS, 16'h0000);
            acc(1'b0, 1'b1, a, 16'h0000);
            chk_mode();
        end
        // Counter wraps while running
        acc(1'b1, 1'b0, `TMS_MODE_OFS, 16'h0080);
        acc(1'b1, 1'b0, `TMS_CNT_OFS, 16'hFFFE);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        @(negedge clk);
        chk(count, 16'hFFFE, "count load");
        @(negedge clk);
        chk(count, 16'hFFFF, "count step");
        @(negedge clk);
        chk(count, 16'h0000, "count wrap");
        // Halted counter holds and reads back
        acc(1'b1, 1'b0, `TMS_MODE_OFS, 16'h0000);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        @(negedge clk);
        v = count;
        repeat (3) @(negedge clk);
        chk(count, v, "halted count");
        acc(1'b0, 1'b1, `TMS_CNT_OFS, 16'h0000);
        exp_q[exp_q.size() - 1] = v;
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        // Reset in mid-run returns every field to its initial value
        acc(1'b1, 1'b0, `TMS_MODE_OFS, 16'h00B7);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        @(negedge clk);
        rst_n = 1'b0;
        mode_m = 8'h00;
        chk_mode();
        rst_n <= 1'b1;
        acc(1'b0, 1'b1, `TMS_MODE_OFS, 16'h0000);
        repeat (3) acc(1'b0, 1'b0, 4'h0, 16'h0000);
        close_out();
    end
endmodule // testbench
